// >>> wd_pkg.sv
package wd_pkg;

   // ****************************************************************
   // Register map and bus constants
   // ****************************************************************

   // Byte offsets of the registers on the APB bus.
   localparam logic [7:0] CTRL_OFFSET = 8'h30;
   localparam logic [7:0] CAUSE_OFFSET = 8'h34;
   localparam logic [7:0] KEY_OFFSET = 8'h38;

   // Signature that opens the protected-change window.
   localparam logic [7:0] UNLOCK_KEY = 8'hD8;

   // Field positions in the control register.
   localparam int FLAG_BIT = 7;
   localparam int IRQEN_BIT = 6;
   localparam int PER3_BIT = 5;
   localparam int EN_BIT = 3;
   localparam int PER_LO_MSB = 2;

   // Field positions in the reset-cause register.
   localparam int CAUSE_WD_BIT = 3;
   localparam int CAUSE_BO_BIT = 2;
   localparam int CAUSE_PIN_BIT = 1;
   localparam int CAUSE_POR_BIT = 0;

   // Reset value of the cause flags: only the power-up flag is set.
   localparam logic [3:0] CAUSE_RESET = 4'h1;

   // ****************************************************************
   // Timing constants
   // ****************************************************************

   // Counter width and the shortest period in oscillator cycles.
   localparam int CNT_W = 18;
   localparam logic [CNT_W:0] PERIOD_BASE = 19'h00200;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
   localparam logic [3:0] PERIOD_FALLBACK = 4'h9;

   // Length of the unlock window in processor cycles.
   localparam logic [2:0] UNLOCK_WINDOW = 3'h4;

   // Bus clock period and the watchdog reset pulse width.
   localparam int PCLK_PERIOD_NS = 25;
   localparam int WD_PULSE_NS = 100;
   localparam int WD_PULSE_INT =
      (WD_PULSE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam logic [3:0] WD_PULSE_CYCLES = 4'(WD_PULSE_INT);

   // ****************************************************************
   // Types
   // ****************************************************************

   // Control register contents as the logic uses them.
   typedef struct packed {
      logic irq_flag;
      logic irq_en;
      logic [3:0] period;
      logic enable;
   } wd_ctrl_t;

   // One APB request as seen by the register decode.
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_t;

   // Watchdog reset sequencer states.
   typedef enum logic [0:0] {
      WD_IDLE,
      WD_PULSE
   } wd_state_t;

endpackage

// >>> wd_sync2.sv
`timescale 1ns/10ps
module wd_sync2 #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Asynchronous inputs and their synchronised copies.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // First stage, read only by the second stage.
   logic [W-1:0] meta_q;

   // Two-flop synchroniser; the first stage may go metastable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// >>> wd_counter.sv
`timescale 1ns/10ps
module wd_counter
   import wd_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic osc_tick,
   input wire logic clear,
   input wire logic run,
   input wire logic [3:0] period,
   // Expiry pulse, one pclk cycle.
   output logic timeout
);

   // Oscillator cycles counted since the last clear.
   logic [CNT_W-1:0] cnt_q;
   // Period code actually in use.
   logic [3:0] eff_code;
   // Count value on which the period ends.
   logic [CNT_W-1:0] last_cnt;

   // Reserved codes fall back to the longest legal period.
   always_comb begin
      eff_code = (period > PERIOD_MAX_CODE) ? PERIOD_FALLBACK : period;
      last_cnt = CNT_W'((PERIOD_BASE << eff_code) - 19'h00001);
   end

   // Count oscillator ticks; clear when stopped or restarted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (clear || !run) begin
            cnt_q <= '0;
         end else if (osc_tick) begin
            if (cnt_q == last_cnt) begin
               cnt_q <= '0;
               timeout <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

endmodule

// >>> wd_timer.sv
// What this block does
// - Counter advances on the 32 kHz oscillator.
// - Restart instruction clears the counter.
// - Disable or chip reset clears the counter.
// - Reset-mode expiry resets the device.
// - Watchdog reset is a short pulse.
// - Level one: starts off, enable freely.
// - Level one: disable needs key then write.
// - Level two: always runs, enable reads one.
// - Level two: period change needs key first.
// - Watchdog, brown-out, pin flags set, zero-clear.
// - Power-up flag cleared only by software.
// - Reserved cause and control bits read zero.
// - Interrupt flag set on interrupt-mode expiry.
// - Flag cleared by vector or writing one.
// - Interrupt needs flag, enable, global enable.
// - Enable bits choose stop, interrupt or reset.
// - Both set: expiry clears interrupt enable.
// - Period code picks 512 to 256K cycles.
// - Reserved period codes use a valid period.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module wd_timer
   import wd_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Processor side, same clock.
   input wire logic restart_instr,
   input wire logic irq_vector_ack,
   input wire logic global_irq_enable,
   output logic wd_irq,
   // Asynchronous inputs from outside the bus domain.
   input wire logic osc_clk_in,
   input wire logic always_on_fuse,
   input wire logic brownout_rst,
   input wire logic pin_rst,
   input wire logic chip_reset,
   // Reset controller side.
   output logic wd_reset_pulse,
   output logic wd_reset_done
);

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************

   // Synchronised copies of the asynchronous inputs.
   logic [4:0] sync_bus;
   logic osc_s;
   logic fuse_s;
   logic bo_s;
   logic pin_s;
   logic chip_rst_s;
   // Previous oscillator level, for edge detection.
   logic osc_prev_q;
   // One-cycle pulse per oscillator rising edge.
   logic osc_tick;

   wd_sync2 #(
      .W(5)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({osc_clk_in, always_on_fuse, brownout_rst, pin_rst,
                 chip_reset}),
      .sync_out(sync_bus)
   );

   assign {osc_s, fuse_s, bo_s, pin_s, chip_rst_s} = sync_bus;

   // Edge detection sits after the synchroniser, never on its first stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_s;
      end
   end

   assign osc_tick = osc_s && !osc_prev_q;

   // ****************************************************************
   // APB slave
   // ****************************************************************

   // Request captured from the bus.
   apb_req_t req;
   // Address decode.
   logic hit_ctrl;
   logic hit_cause;
   logic hit_key;
   logic mapped;
   // Edge at which a transfer completes.
   logic access;
   logic wr_ctrl;
   logic wr_cause;
   logic wr_key;
   // Readable images of the registers.
   logic [7:0] ctrl_rd;
   logic [7:0] cause_rd;
   logic [7:0] rd_mux;

   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign hit_ctrl = (req.addr == CTRL_OFFSET);
   assign hit_cause = (req.addr == CAUSE_OFFSET);
   assign hit_key = (req.addr == KEY_OFFSET);
   assign mapped = hit_ctrl || hit_cause || hit_key;
   assign access = psel && penable && pready;
   assign wr_ctrl = access && req.write && hit_ctrl && !pslverr;
   assign wr_cause = access && req.write && hit_cause && !pslverr;
   assign wr_key = access && req.write && hit_key && !pslverr;

   // Read data is sampled during setup, so it is stable in access.
   always_comb begin
      if (hit_ctrl) begin
         rd_mux = ctrl_rd;
      end else if (hit_cause) begin
         rd_mux = cause_rd;
      end else begin
         // The key register reads as zero, as does an unmapped word.
         rd_mux = 8'h00;
      end
   end

   // No wait states: pready rises in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         // Setup phase: prepare the answer.
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= {24'h000000, rd_mux};
      end else begin
         // Answer stands for one cycle only.
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
   end

   // ****************************************************************
   // Change protection
   // ****************************************************************

   // Cycles left in the unlock window; zero means locked.
   logic [2:0] unlock_cnt_q;
   logic unlocked;

   assign unlocked = (unlock_cnt_q != 3'h0);

   // The key opens a short window; the control write closes it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_cnt_q <= 3'h0;
      end else if (chip_rst_s) begin
         unlock_cnt_q <= 3'h0;
      end else if (wr_key && req.wdata[7:0] == UNLOCK_KEY) begin
         unlock_cnt_q <= UNLOCK_WINDOW;
      end else if (wr_ctrl) begin
         unlock_cnt_q <= 3'h0;
      end else if (unlocked) begin
         unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************

   // Stored control fields.
   wd_ctrl_t ctrl_q;
   // Safety level two when the fuse is programmed.
   logic level2;
   // Enable as the logic and software see it.
   logic enable_eff;
   logic run;
   logic timeout;
   logic wd_fire;
   logic [3:0] wr_period;

   assign level2 = fuse_s;
   assign enable_eff = ctrl_q.enable || level2;
   assign run = enable_eff || ctrl_q.irq_en;
   assign wr_period = {req.wdata[PER3_BIT], req.wdata[PER_LO_MSB:0]};
   assign wd_fire = timeout && enable_eff && !ctrl_q.irq_en;
   assign ctrl_rd = {ctrl_q.irq_flag, ctrl_q.irq_en, ctrl_q.period[3],
                     1'b0, enable_eff, ctrl_q.period[2:0]};

   // Software writes with protection, plus hardware updates on expiry.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
      end else if (chip_rst_s) begin
         // Chip reset restores the initial, disabled state.
         ctrl_q <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q.irq_en <= req.wdata[IRQEN_BIT];
            if (level2) begin
               // Enable written value is ignored here.
               if (unlocked) begin
                  ctrl_q.period <= wr_period;
               end
            end else begin
               ctrl_q.period <= wr_period;
               if (unlocked) begin
                  ctrl_q.enable <= req.wdata[EN_BIT];
               end else begin
                  // Setting is free; clearing is refused.
                  ctrl_q.enable <= ctrl_q.enable ||
                                   req.wdata[EN_BIT];
               end
            end
         end
         // Expiry with both bits set drops back to reset mode.
         if (timeout && enable_eff && ctrl_q.irq_en) begin
            ctrl_q.irq_en <= 1'b0;
         end
         // Flag: the set wins over a clear in the same cycle.
         if (timeout && ctrl_q.irq_en) begin
            ctrl_q.irq_flag <= 1'b1;
         end else if (irq_vector_ack ||
                      (wr_ctrl && req.wdata[FLAG_BIT])) begin
            ctrl_q.irq_flag <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Counter
   // ****************************************************************

   // Clear on restart, on chip reset, and during our own reset pulse.
   logic cnt_clear;

   assign cnt_clear = restart_instr || chip_rst_s ||
                      wd_reset_pulse;

   wd_counter u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .osc_tick(osc_tick),
      .clear(cnt_clear),
      .run(run),
      .period(ctrl_q.period),
      .timeout(timeout)
   );

   // ****************************************************************
   // Interrupt request
   // ****************************************************************

   // Request only while flag, enable and global enable all hold.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_irq <= 1'b0;
      end else begin
         wd_irq <= ctrl_q.irq_flag && ctrl_q.irq_en &&
                   global_irq_enable;
      end
   end

   // ****************************************************************
   // Watchdog reset sequencer
   // ****************************************************************

   // Sequencer state and pulse length counter.
   wd_state_t state_q;
   logic [3:0] pulse_cnt_q;

   // A short pulse; its falling edge is marked for the delay counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= WD_IDLE;
         pulse_cnt_q <= 4'h0;
         wd_reset_pulse <= 1'b0;
         wd_reset_done <= 1'b0;
      end else begin
         wd_reset_done <= 1'b0;
         unique case (state_q)
            WD_IDLE: begin
               if (wd_fire) begin
                  state_q <= WD_PULSE;
                  pulse_cnt_q <= WD_PULSE_CYCLES - 4'h1;
                  wd_reset_pulse <= 1'b1;
               end
            end
            WD_PULSE: begin
               if (pulse_cnt_q == 4'h0) begin
                  state_q <= WD_IDLE;
                  wd_reset_pulse <= 1'b0;
                  wd_reset_done <= 1'b1;
               end else begin
                  pulse_cnt_q <= pulse_cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Reset-cause flags
   // ****************************************************************

   // Only the power-up reset reinitialises these; they survive chip resets.
   logic [3:0] cause_q;

   assign cause_rd = {4'h0, cause_q};

   // Watchdog, brown-out and pin flags: a set wins over a software zero in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= CAUSE_RESET;
      end else begin
         if (wr_cause) begin
            // Writing zero clears; writing one leaves a flag alone.
            cause_q <= cause_q & req.wdata[3:0];
         end
         if (wd_fire) begin
            cause_q[CAUSE_WD_BIT] <= 1'b1;
         end
         if (bo_s) begin
            cause_q[CAUSE_BO_BIT] <= 1'b1;
         end
         if (pin_s) begin
            cause_q[CAUSE_PIN_BIT] <= 1'b1;
         end
      end
   end

endmodule

// >>> wd_timer_chk_sva.sv
`timescale 1ns/10ps
module wd_timer_chk
   import wd_pkg::*;
(
   // Clock, reset and bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Processor and reset controller side.
   input wire logic restart_instr,
   input wire logic global_irq_enable,
   input wire logic wd_irq,
   input wire logic wd_reset_pulse,
   input wire logic wd_reset_done
);
   // A single clock domain, so clock and reset are given once here.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ****************
   // Bus behaviour
   // ****************
   setup_ready_a:
      assert property (psel && !penable |=> pready)
      else $error("no answer in first access cycle");
   ready_single_a:
      assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_access_a:
      assert property (pready |-> psel && penable)
      else $error("ready outside an access");
   err_ready_a:
      assert property (pslverr |-> pready)
      else $error("error without ready");
   upper_zero_a:
      assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   ctrl_rsvd_a:
      assert property (pready && !pwrite && paddr == CTRL_OFFSET
                       |-> !prdata[4])
      else $error("control bit 4 not zero");
   cause_rsvd_a:
      assert property (pready && !pwrite && paddr == CAUSE_OFFSET
                       |-> prdata[7:4] == 4'h0)
      else $error("cause upper bits not zero");
   // ****************
   // Timer outputs
   // ****************
   pulse_width_a:
      assert property ($rose(wd_reset_pulse)
                       |-> wd_reset_pulse[*4] ##1 !wd_reset_pulse)
      else $error("reset pulse width wrong");
   done_fall_a:
      assert property ($fell(wd_reset_pulse) |-> ##[0:1] wd_reset_done)
      else $error("no done after pulse fall");
   irq_gate_a:
      assert property (wd_irq |-> $past(global_irq_enable))
      else $error("interrupt without global enable");
   restart_quiet_a:
      assert property (restart_instr
                       |-> ##4 (!$rose(wd_reset_pulse))[*8])
      else $error("reset pulse just after restart");
   // Main scenarios reached.
   pulse_c: cover property ($rose(wd_reset_pulse));
   irq_c: cover property ($rose(wd_irq));
   err_c: cover property (pslverr);
endmodule

bind wd_timer wd_timer_chk wd_timer_chk_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pready, .prdata, .pslverr, .restart_instr,
   .global_irq_enable, .wd_irq, .wd_reset_pulse, .wd_reset_done);

// >>> core_model.sv
`timescale 1ns/10ps
module core_model (
   // Bus clock.
   input wire logic pclk,
   // Oscillator and instruction strobes.
   output logic osc_clk_in,
   output logic restart_instr,
   output logic irq_vector_ack
);
   logic [1:0] div_q; // Half-period count of the oscillator.
   initial begin
      {osc_clk_in, restart_instr, irq_vector_ack} = 3'h0;
      div_q = 2'h0;
   end
   // The oscillator runs free; four bus cycles a half period is the
   // fastest the design accepts, which keeps the long periods short.
   always @(posedge pclk) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
         osc_clk_in <= !osc_clk_in;
      end
   end
   // One-cycle strobe: the restart instruction or the vector taken.
   task automatic strobe(input logic restart);
      @(posedge pclk);
      if (restart) begin
         restart_instr <= 1'b1;
      end else begin
         irq_vector_ack <= 1'b1;
      end
      @(posedge pclk);
      {restart_instr, irq_vector_ack} <= 2'h0;
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import wd_pkg::*;
   // Bench-driven design inputs.
   logic pclk, presetn, psel, penable, pwrite, global_irq_enable;
   logic always_on_fuse, brownout_rst, pin_rst, chip_reset;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   // Design and partner outputs.
   logic pready, pslverr, wd_irq, wd_reset_pulse, wd_reset_done;
   logic osc_clk_in, restart_instr, irq_vector_ack, err;
   logic [7:0] rd;
   int failures, tests_run;

   wd_timer wd_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .restart_instr,
      .irq_vector_ack, .global_irq_enable, .wd_irq, .osc_clk_in,
      .always_on_fuse, .brownout_rst, .pin_rst, .chip_reset,
      .wd_reset_pulse, .wd_reset_done);
   core_model core_model_inst (.pclk, .osc_clk_in, .restart_instr,
      .irq_vector_ack);

   // 40 MHz bus clock.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = !pclk;
   end
   // ****************
   // Compare and bus tasks
   // ****************
   task automatic check_reg(input string what, input logic [7:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   // One transfer; the request stands until ready is sampled high.
   // No cycle count is assumed: only the watchdog ends a hung wait.
   task automatic apb(input logic wr, input logic [7:0] a, d,
                      output logic [7:0] q, output logic e);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata[7:0];
      e = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, d);
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, exp);
      apb(1'b0, a, 8'h00, rd, err);
      check_reg(what, exp, rd);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Counts cycles to the interrupt or reset pulse; it must fall in
   // the window, since a tick is eight bus cycles.
   task automatic wait_for(input logic irq, input int lo, hi);
      int n;
      n = 0;
      while ((irq ? wd_irq : wd_reset_pulse) !== 1'b1 && n < hi) begin
         @(posedge pclk);
         n++;
      end
      check_bit("expiry time", 1'b1, n >= lo && n < hi);
   endtask
   // Drives the pin and brown-out sources, then lets them settle.
   task automatic set_src(input logic [1:0] src);
      {pin_rst, brownout_rst} <= src;
      idle(5);
   endtask
   // A chip reset as the system would give after a watchdog reset.
   task automatic chip_rst;
      chip_reset <= 1'b1;
      idle(5);
      chip_reset <= 1'b0;
      idle(4);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Guards against a hang; the tests need about 35000 cycles.
   initial begin
      idle(80000);
      failures++;
      report_and_stop;
   end
   // ****************
   // Test sequence
   // ****************
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = 43'h0;
      {global_irq_enable, always_on_fuse, brownout_rst} = 3'h0;
      {pin_rst, chip_reset, presetn} = 3'h0;
      {failures, tests_run} = 64'h0;
      idle(10);
      presetn <= 1'b1;
      rdc("ctrl", CTRL_OFFSET, 8'h00);
      rdc("cause", CAUSE_OFFSET, 8'h01);
      rdc("key", KEY_OFFSET, 8'h00);
      apb(1'b0, 8'h3C, 8'h00, rd, err);
      check_bit("unmapped", 1'b1, err);
      $display("test reset values done");
      wr(CAUSE_OFFSET, 8'h00);
      rdc("cause", CAUSE_OFFSET, 8'h00);
      set_src(2'h2);
      set_src(2'h0);
      rdc("cause", CAUSE_OFFSET, 8'h02);
      set_src(2'h1);
      set_src(2'h0);
      rdc("cause", CAUSE_OFFSET, 8'h06);
      wr(CAUSE_OFFSET, 8'hFF);
      rdc("cause", CAUSE_OFFSET, 8'h06);
      wr(CAUSE_OFFSET, 8'h02);
      rdc("cause", CAUSE_OFFSET, 8'h02);
      wr(CAUSE_OFFSET, 8'h00);
      $display("test cause flags done");
      wr(CTRL_OFFSET, 8'h31);
      rdc("ctrl", CTRL_OFFSET, 8'h21);
      wr(CTRL_OFFSET, 8'h08);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      wr(CTRL_OFFSET, 8'h00);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      wr(KEY_OFFSET, UNLOCK_KEY);
      idle(6);
      wr(CTRL_OFFSET, 8'h00);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      wr(KEY_OFFSET, UNLOCK_KEY);
      wr(CTRL_OFFSET, 8'h00);
      rdc("ctrl", CTRL_OFFSET, 8'h00);
      $display("test level one done");
      wr(CTRL_OFFSET, 8'h08);
      core_model_inst.strobe(1'b1);
      idle(3000);
      core_model_inst.strobe(1'b1);
      wait_for(1'b0, 4000, 4200);
      idle(8);
      rdc("cause", CAUSE_OFFSET, 8'h08);
      idle(3000);
      wr(KEY_OFFSET, UNLOCK_KEY);
      wr(CTRL_OFFSET, 8'h00);
      wr(CTRL_OFFSET, 8'h08);
      wait_for(1'b0, 4000, 4200);
      chip_rst;
      rdc("ctrl", CTRL_OFFSET, 8'h00);
      wr(CAUSE_OFFSET, 8'h00);
      $display("test reset expiry done");
      wr(CTRL_OFFSET, 8'h40);
      core_model_inst.strobe(1'b1);
      idle(4300);
      rdc("ctrl", CTRL_OFFSET, 8'hC0);
      check_bit("irq masked", 1'b0, wd_irq);
      global_irq_enable <= 1'b1;
      idle(3);
      check_bit("irq", 1'b1, wd_irq);
      core_model_inst.strobe(1'b0);
      idle(3);
      rdc("ctrl", CTRL_OFFSET, 8'h40);
      check_bit("irq cleared", 1'b0, wd_irq);
      wr(CTRL_OFFSET, 8'h48);
      core_model_inst.strobe(1'b1);
      idle(4300);
      check_bit("no reset", 1'b0, wd_reset_pulse);
      rdc("ctrl", CTRL_OFFSET, 8'h88);
      rdc("cause", CAUSE_OFFSET, 8'h00);
      wr(CTRL_OFFSET, 8'h88);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      core_model_inst.strobe(1'b1);
      wait_for(1'b0, 4000, 4200);
      chip_rst;
      $display("test interrupt mode done");
      always_on_fuse <= 1'b1;
      idle(5);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      wr(CTRL_OFFSET, 8'h01);
      rdc("ctrl", CTRL_OFFSET, 8'h08);
      wr(KEY_OFFSET, UNLOCK_KEY);
      wr(CTRL_OFFSET, 8'h01);
      rdc("ctrl", CTRL_OFFSET, 8'h09);
      core_model_inst.strobe(1'b1);
      wait_for(1'b0, 8100, 8300);
      $display("test level two done");
      report_and_stop;
   end
endmodule
